// ### hdl/sca_strap_config.sv
module sca_strap_config (
    input wire logic clk,
    input wire logic rst_b,
    input wire sca_pkg::sca_straps_t straps,
    input wire sca_pkg::sca_io_wr_t io_wr,
    output sca_pkg::sca_cfg_t cfg,
    output logic cfg_mode,
    output logic [3:0] cfg_index,
    output logic cfg_data_wr,
    output logic [7:0] cfg_data
);

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture: an armed flag catches the straps once on the first edge
    // after reset release, so no port value enters an asynchronous reset.

    logic armed_reg;
    logic armed_next;
    sca_pkg::sca_straps_t strap_reg;
    sca_pkg::sca_straps_t strap_next;

    always_comb begin
        armed_next = 1'b1;
        strap_next = armed_reg ? strap_reg : straps;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_reg <= 1'b0;
            strap_reg <= '0;
        end else begin
            armed_reg <= armed_next;
            strap_reg <= strap_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoders.

    function automatic logic [9:0] uart_a_base(input logic [1:0] s);
        case (s)
            2'h1: uart_a_base = sca_pkg::SCA_COM3_BASE;
            2'h2: uart_a_base = sca_pkg::SCA_COM2_BASE;
            2'h3: uart_a_base = sca_pkg::SCA_COM1_BASE;
            default: uart_a_base = 10'h000;
        endcase
    endfunction

    function automatic logic [9:0] uart_b_base(input logic [1:0] s);
        case (s)
            2'h1: uart_b_base = sca_pkg::SCA_COM4_BASE;
            2'h2: uart_b_base = sca_pkg::SCA_COM1_BASE;
            2'h3: uart_b_base = sca_pkg::SCA_COM2_BASE;
            default: uart_b_base = 10'h000;
        endcase
    endfunction

    function automatic logic [9:0] par_base(input logic [1:0] s);
        case (s)
            2'h1: par_base = sca_pkg::SCA_PAR_BASE_A;
            2'h2: par_base = sca_pkg::SCA_PAR_BASE_B;
            2'h3: par_base = sca_pkg::SCA_PAR_BASE_C;
            default: par_base = 10'h000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Unlock sequencer and index/software floppy state.

    sca_pkg::sca_state_t state_reg;
    sca_pkg::sca_state_t state_next;
    logic [3:0] index_reg;
    logic [3:0] index_next;
    logic index_ok_reg;
    logic index_ok_next;
    logic [7:0] sw_floppy_reg;
    logic [7:0] sw_floppy_next;
    logic dwr_reg;
    logic dwr_next;
    logic [7:0] ddat_reg;
    logic [7:0] ddat_next;
    sca_pkg::sca_cfg_t cfg_reg;
    sca_pkg::sca_cfg_t cfg_next;

    logic [9:0] sel_addr;
    logic [9:0] dat_addr;
    logic sel_hit;
    logic dat_hit;
    logic floppy_sw;

    always_comb begin
        sel_addr = strap_reg.floppy_addr_strap ? sca_pkg::SCA_CFG_SEL_SEC
                                               : sca_pkg::SCA_CFG_SEL_PRI;
        dat_addr = strap_reg.floppy_addr_strap ? sca_pkg::SCA_CFG_DAT_SEC
                                               : sca_pkg::SCA_CFG_DAT_PRI;
        sel_hit = io_wr.wr && io_wr.addr == sel_addr;
        dat_hit = io_wr.wr && io_wr.addr == dat_addr;
        floppy_sw = !strap_reg.floppy_enable_strap;
    end

    always_comb begin
        state_next = state_reg;
        index_next = index_reg;
        index_ok_next = index_ok_reg;
        sw_floppy_next = sw_floppy_reg;
        dwr_next = 1'b0;
        ddat_next = ddat_reg;
        case (state_reg)
            sca_pkg::SCA_ST_IDLE: begin
                if (sel_hit && io_wr.data == sca_pkg::SCA_KEY_ENTER) begin
                    state_next = sca_pkg::SCA_ST_KEY1;
                end
            end
            sca_pkg::SCA_ST_KEY1: begin
                if (io_wr.wr) begin
                    if (sel_hit && io_wr.data == sca_pkg::SCA_KEY_ENTER) begin
                        state_next = sca_pkg::SCA_ST_CFG;
                        index_ok_next = 1'b0;
                    end else begin
                        state_next = sca_pkg::SCA_ST_IDLE;
                    end
                end
            end
            sca_pkg::SCA_ST_CFG: begin
                if (sel_hit && io_wr.data == sca_pkg::SCA_KEY_EXIT) begin
                    state_next = sca_pkg::SCA_ST_IDLE;
                    index_ok_next = 1'b0;
                end else if (sel_hit) begin
                    index_next = io_wr.data[3:0];
                    index_ok_next = io_wr.data[7:4] == 4'h0;
                end else if (dat_hit && index_ok_reg) begin
                    dwr_next = 1'b1;
                    ddat_next = io_wr.data;
                    // Floppy fields are writable only while the floppy strap leaves
                    // them free; every other strap-fixed setting has no writable copy.
                    if (index_reg == sca_pkg::SCA_IDX_FLOPPY && floppy_sw) begin
                        sw_floppy_next = io_wr.data;
                    end
                end
            end
            default: state_next = sca_pkg::SCA_ST_IDLE;
        endcase
    end

    always_comb begin
        cfg_next.par_en = strap_reg.par_addr_strap_hi | strap_reg.par_addr_strap_lo;
        cfg_next.par_base = par_base({strap_reg.par_addr_strap_hi,
                                      strap_reg.par_addr_strap_lo});
        cfg_next.par_mode = sca_pkg::sca_par_mode_t'({strap_reg.par_ext_cap_strap,
                                                      strap_reg.par_pad_mode_strap});
        cfg_next.uart_a_en = strap_reg.uart_a_addr_strap_hi | strap_reg.uart_a_addr_strap_lo;
        cfg_next.uart_a_base = uart_a_base({strap_reg.uart_a_addr_strap_hi,
                                            strap_reg.uart_a_addr_strap_lo});
        cfg_next.uart_b_en = strap_reg.uart_b_addr_strap_hi | strap_reg.uart_b_addr_strap_lo;
        cfg_next.uart_b_base = uart_b_base({strap_reg.uart_b_addr_strap_hi,
                                            strap_reg.uart_b_addr_strap_lo});
        cfg_next.disk_if = sca_pkg::sca_disk_t'({strap_reg.disk_if_enable_strap,
                                                 strap_reg.disk_if_addr_strap});
        if (floppy_sw) begin
            cfg_next.floppy_en = sw_floppy_reg[sca_pkg::SCA_SW_FLOPPY_EN_BIT];
            cfg_next.floppy_sec = sw_floppy_reg[sca_pkg::SCA_SW_FLOPPY_SEC_BIT];
            cfg_next.floppy_mode2_ok = 1'b1;
            cfg_next.data_rate_out = 1'b0;
        end else begin
            cfg_next.floppy_en = 1'b1;
            cfg_next.floppy_sec = strap_reg.floppy_addr_strap;
            cfg_next.floppy_mode2_ok = 1'b0;
            cfg_next.data_rate_out = 1'b1;
        end
        cfg_next.cfg_sel_addr = sel_addr;
        cfg_next.cfg_dat_addr = dat_addr;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= sca_pkg::SCA_ST_IDLE;
            index_reg <= sca_pkg::SCA_IDX_RESET;
            index_ok_reg <= 1'b0;
            sw_floppy_reg <= sca_pkg::SCA_SW_FLOPPY_RESET;
            dwr_reg <= 1'b0;
            ddat_reg <= 8'h00;
            cfg_reg <= '0;
        end else begin
            state_reg <= state_next;
            index_reg <= index_next;
            index_ok_reg <= index_ok_next;
            sw_floppy_reg <= sw_floppy_next;
            dwr_reg <= dwr_next;
            ddat_reg <= ddat_next;
            cfg_reg <= cfg_next;
        end
    end

    assign cfg = cfg_reg;
    assign cfg_mode = state_reg == sca_pkg::SCA_ST_CFG;
    assign cfg_index = index_reg;
    assign cfg_data_wr = dwr_reg;
    assign cfg_data = ddat_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence key_pair;
        sel_hit && io_wr.data == sca_pkg::SCA_KEY_ENTER && state_reg == sca_pkg::SCA_ST_IDLE
        ##1 sel_hit && io_wr.data == sca_pkg::SCA_KEY_ENTER;
    endsequence

    chk_unlock_pair: assert property (key_pair |=> cfg_mode)
        else $error("two key writes did not unlock");
    chk_unlock_break: assert property (state_reg == sca_pkg::SCA_ST_KEY1
        && io_wr.wr && !(sel_hit && io_wr.data == sca_pkg::SCA_KEY_ENTER) |=> !cfg_mode)
        else $error("interrupted key pair unlocked");
    chk_enter_only: assert property ($rose(cfg_mode) |-> $past(sel_hit, 1)
        && $past(io_wr.data, 1) == sca_pkg::SCA_KEY_ENTER
        && $past(state_reg, 1) == sca_pkg::SCA_ST_KEY1)
        else $error("configuration entered without key pair");
    chk_exit_key: assert property (cfg_mode && sel_hit
        && io_wr.data == sca_pkg::SCA_KEY_EXIT |=> !cfg_mode)
        else $error("exit key ignored");
    chk_strap_hold: assert property (armed_reg |=> $stable(strap_reg))
        else $error("latched straps changed");
    chk_par_decode: assert property (armed_reg ##1 1 |=> cfg.par_en
        == $past(strap_reg.par_addr_strap_hi || strap_reg.par_addr_strap_lo, 2))
        else $error("parallel enable decode wrong");
    chk_floppy_fixed: assert property (strap_reg.floppy_enable_strap
        |=> cfg.data_rate_out && !cfg.floppy_mode2_ok)
        else $error("floppy strap 1 not honoured");
    chk_data_gate: assert property (cfg_data_wr |-> $past(cfg_mode, 1)
        && $past(index_ok_reg, 1) && $past(dat_hit, 1))
        else $error("data write without selected index");
    chk_cfg_port: assert property (cfg.cfg_sel_addr != sca_pkg::SCA_CFG_SEL_SEC
        || $past(strap_reg.floppy_addr_strap, 1))
        else $error("select port placement wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Decode checks: every strap setting except printer mode and disk off is checked one edge later.

    logic [1:0] par_pick;
    logic [1:0] mode_pick;
    logic [1:0] uart_a_pick;
    logic [1:0] uart_b_pick;
    logic [1:0] disk_pick;
    logic [1:0] floppy_pick;

    assign par_pick = {strap_reg.par_addr_strap_hi, strap_reg.par_addr_strap_lo};
    assign mode_pick = {strap_reg.par_ext_cap_strap, strap_reg.par_pad_mode_strap};
    assign uart_a_pick = {strap_reg.uart_a_addr_strap_hi, strap_reg.uart_a_addr_strap_lo};
    assign uart_b_pick = {strap_reg.uart_b_addr_strap_hi, strap_reg.uart_b_addr_strap_lo};
    assign disk_pick = {strap_reg.disk_if_enable_strap, strap_reg.disk_if_addr_strap};
    assign floppy_pick = {strap_reg.floppy_enable_strap, strap_reg.floppy_addr_strap};

    chk_par_off: assert property (par_pick == 2'h0 |=> !cfg.par_en)
        else $error("parallel port not disabled");
    chk_par_base_a: assert property (par_pick == 2'h1
        |=> cfg.par_en && cfg.par_base == sca_pkg::SCA_PAR_BASE_A)
        else $error("parallel base A wrong");
    chk_par_base_b: assert property (par_pick == 2'h2
        |=> cfg.par_en && cfg.par_base == sca_pkg::SCA_PAR_BASE_B)
        else $error("parallel base B wrong");
    chk_par_base_c: assert property (par_pick == 2'h3
        |=> cfg.par_en && cfg.par_base == sca_pkg::SCA_PAR_BASE_C)
        else $error("parallel base C wrong");
    chk_mode_epp: assert property (mode_pick == 2'h1
        |=> cfg.par_mode == sca_pkg::SCA_PAR_EPP)
        else $error("EPP mode wrong");
    chk_mode_ecp: assert property (mode_pick == 2'h2
        |=> cfg.par_mode == sca_pkg::SCA_PAR_ECP)
        else $error("ECP mode wrong");
    chk_mode_both: assert property (mode_pick == 2'h3
        |=> cfg.par_mode == sca_pkg::SCA_PAR_ECP_EPP)
        else $error("combined parallel mode wrong");
    chk_uart_a_off: assert property (uart_a_pick == 2'h0 |=> !cfg.uart_a_en)
        else $error("primary serial not disabled");
    chk_uart_a_com3: assert property (uart_a_pick == 2'h1
        |=> cfg.uart_a_en && cfg.uart_a_base == sca_pkg::SCA_COM3_BASE)
        else $error("primary serial COM3 wrong");
    chk_uart_a_com2: assert property (uart_a_pick == 2'h2
        |=> cfg.uart_a_en && cfg.uart_a_base == sca_pkg::SCA_COM2_BASE)
        else $error("primary serial COM2 wrong");
    chk_uart_a_com1: assert property (uart_a_pick == 2'h3
        |=> cfg.uart_a_en && cfg.uart_a_base == sca_pkg::SCA_COM1_BASE)
        else $error("primary serial COM1 wrong");
    chk_uart_b_off: assert property (uart_b_pick == 2'h0 |=> !cfg.uart_b_en)
        else $error("secondary serial not disabled");
    chk_uart_b_com4: assert property (uart_b_pick == 2'h1
        |=> cfg.uart_b_en && cfg.uart_b_base == sca_pkg::SCA_COM4_BASE)
        else $error("secondary serial COM4 wrong");
    chk_uart_b_com1: assert property (uart_b_pick == 2'h2
        |=> cfg.uart_b_en && cfg.uart_b_base == sca_pkg::SCA_COM1_BASE)
        else $error("secondary serial COM1 wrong");
    chk_uart_b_com2: assert property (uart_b_pick == 2'h3
        |=> cfg.uart_b_en && cfg.uart_b_base == sca_pkg::SCA_COM2_BASE)
        else $error("secondary serial COM2 wrong");
    chk_disk_rsvd: assert property (disk_pick == 2'h1
        |=> cfg.disk_if == sca_pkg::SCA_DISK_RSVD)
        else $error("disk reserved setting wrong");
    chk_disk_pri: assert property (disk_pick == 2'h2
        |=> cfg.disk_if == sca_pkg::SCA_DISK_PRI)
        else $error("disk primary setting wrong");
    chk_disk_sec: assert property (disk_pick == 2'h3
        |=> cfg.disk_if == sca_pkg::SCA_DISK_SEC)
        else $error("disk secondary setting wrong");
    chk_floppy_free: assert property (!strap_reg.floppy_enable_strap
        |=> cfg.floppy_mode2_ok && !cfg.data_rate_out)
        else $error("floppy strap 0 not honoured");
    chk_floppy_pos: assert property (strap_reg.floppy_enable_strap
        |=> cfg.floppy_en && cfg.floppy_sec == $past(strap_reg.floppy_addr_strap, 1))
        else $error("fixed floppy placement wrong");
    chk_sw_locked: assert property (strap_reg.floppy_enable_strap |=> $stable(sw_floppy_reg))
        else $error("fixed floppy setting changed");
    chk_pri_ports: assert property (floppy_pick == 2'h0
        |=> cfg.cfg_sel_addr == sca_pkg::SCA_CFG_SEL_PRI && cfg.cfg_dat_addr == sca_pkg::SCA_CFG_DAT_PRI)
        else $error("primary configuration ports wrong");
    chk_sec_ports: assert property (floppy_pick == 2'h1
        |=> cfg.cfg_sel_addr == sca_pkg::SCA_CFG_SEL_SEC && cfg.cfg_dat_addr == sca_pkg::SCA_CFG_DAT_SEC)
        else $error("secondary configuration ports wrong");
    chk_reset_idle: assert property ($rose(armed_reg)
        |-> $past(state_reg, 1) == sca_pkg::SCA_ST_IDLE && !$past(index_ok_reg, 1))
        else $error("reset left unlock state");

endmodule // sca_strap_config

// ### shared/sca_pkg.sv
package sca_pkg;
    localparam logic [9:0] SCA_PAR_BASE_A = 10'h3bc;
    localparam logic [9:0] SCA_PAR_BASE_B = 10'h378;
    localparam logic [9:0] SCA_PAR_BASE_C = 10'h278;
    localparam logic [9:0] SCA_COM1_BASE = 10'h3f8;
    localparam logic [9:0] SCA_COM2_BASE = 10'h2f8;
    localparam logic [9:0] SCA_COM3_BASE = 10'h3e8;
    localparam logic [9:0] SCA_COM4_BASE = 10'h2e8;
    localparam logic [9:0] SCA_CFG_SEL_PRI = 10'h3f0;
    localparam logic [9:0] SCA_CFG_DAT_PRI = 10'h3f1;
    localparam logic [9:0] SCA_CFG_SEL_SEC = 10'h370;
    localparam logic [9:0] SCA_CFG_DAT_SEC = 10'h371;
    localparam logic [7:0] SCA_KEY_ENTER = 8'h44;
    localparam logic [7:0] SCA_KEY_EXIT = 8'haa;
    localparam logic [3:0] SCA_IDX_RESET = 4'h0;
    localparam logic [7:0] SCA_SW_FLOPPY_RESET = 8'h00;
    localparam int SCA_SW_FLOPPY_EN_BIT = 0;
    localparam int SCA_SW_FLOPPY_SEC_BIT = 1;
    localparam int SCA_SW_FLOPPY_MODE2_BIT = 2;
    localparam logic [3:0] SCA_IDX_FLOPPY = 4'h0;

    typedef enum logic [1:0] {
        SCA_PAR_PRINTER = 2'h0,
        SCA_PAR_EPP = 2'h1,
        SCA_PAR_ECP = 2'h2,
        SCA_PAR_ECP_EPP = 2'h3
    } sca_par_mode_t;

    typedef enum logic [1:0] {
        SCA_DISK_OFF = 2'h0,
        SCA_DISK_RSVD = 2'h1,
        SCA_DISK_PRI = 2'h2,
        SCA_DISK_SEC = 2'h3
    } sca_disk_t;

    typedef enum logic [2:0] {
        SCA_ST_IDLE = 3'b001,
        SCA_ST_KEY1 = 3'b010,
        SCA_ST_CFG = 3'b100
    } sca_state_t;

    typedef struct packed {
        logic par_addr_strap_hi;
        logic par_addr_strap_lo;
        logic par_ext_cap_strap;
        logic par_pad_mode_strap;
        logic uart_a_addr_strap_hi;
        logic uart_a_addr_strap_lo;
        logic uart_b_addr_strap_hi;
        logic uart_b_addr_strap_lo;
        logic disk_if_enable_strap;
        logic disk_if_addr_strap;
        logic floppy_enable_strap;
        logic floppy_addr_strap;
    } sca_straps_t;

    typedef struct packed {
        logic par_en;
        logic [9:0] par_base;
        sca_par_mode_t par_mode;
        logic uart_a_en;
        logic [9:0] uart_a_base;
        logic uart_b_en;
        logic [9:0] uart_b_base;
        sca_disk_t disk_if;
        logic floppy_en;
        logic floppy_sec;
        logic floppy_mode2_ok;
        logic data_rate_out;
        logic [9:0] cfg_sel_addr;
        logic [9:0] cfg_dat_addr;
    } sca_cfg_t;

    typedef struct packed {
        logic wr;
        logic [9:0] addr;
        logic [7:0] data;
    } sca_io_wr_t;
endpackage

// ### verification/sca_host_model.sv
module sca_host_model (
    input wire logic clk,
    output sca_pkg::sca_io_wr_t io_wr
);
    timeunit 1ns;
    timeprecision 1ns;

    initial io_wr = '0;

    // Starts one write cycle; calls on successive falling edges give back-to-back writes.
    task automatic put(input logic [9:0] addr, input logic [7:0] data);
        @(negedge clk);
        io_wr = {1'b1, addr, data};
    endtask

    // Drops the strobe; released address and data lines change so stale values never match.
    task automatic idle();
        @(negedge clk);
        io_wr = {1'b0, ~io_wr.addr, ~io_wr.data};
    endtask

    // Both keys go out with no other access between them.
    task automatic unlock(input logic [9:0] sel);
        put(sel, sca_pkg::SCA_KEY_ENTER);
        put(sel, sca_pkg::SCA_KEY_ENTER);
        idle();
    endtask
endmodule // sca_host_model

// ### verification/tb_strap_config_and_unlock.sv
module tb_strap_config_and_unlock;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sca_pkg::sca_straps_t straps = '0;
    sca_pkg::sca_straps_t latched;
    sca_pkg::sca_io_wr_t io_wr;
    sca_pkg::sca_cfg_t cfg;
    sca_pkg::sca_cfg_t seen;
    logic cfg_mode;
    logic [3:0] cfg_index;
    logic cfg_data_wr;
    logic [7:0] cfg_data;
    logic [9:0] sel;
    logic [9:0] dat;
    logic [9:0] other;
    logic [31:0] r;
    int num_errors = 0;
    int check_count = 0;
    int seed = 32'hd3ac162f;

    always #25 clk = ~clk;

    sca_host_model host (.clk(clk), .io_wr(io_wr));
    sca_strap_config DUT (.clk(clk), .rst_b(rst_b), .straps(straps), .io_wr(io_wr),
        .cfg(cfg), .cfg_mode(cfg_mode), .cfg_index(cfg_index), .cfg_data_wr(cfg_data_wr),
        .cfg_data(cfg_data));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic sca_pkg::sca_cfg_t expect_cfg(sca_pkg::sca_straps_t s, logic [1:0] sw);
        sca_pkg::sca_cfg_t c;
        logic [9:0] pt [4];
        logic [9:0] at [4];
        logic [9:0] bt [4];
        pt = '{10'h000, sca_pkg::SCA_PAR_BASE_A, sca_pkg::SCA_PAR_BASE_B, sca_pkg::SCA_PAR_BASE_C};
        at = '{10'h000, sca_pkg::SCA_COM3_BASE, sca_pkg::SCA_COM2_BASE, sca_pkg::SCA_COM1_BASE};
        bt = '{10'h000, sca_pkg::SCA_COM4_BASE, sca_pkg::SCA_COM1_BASE, sca_pkg::SCA_COM2_BASE};
        c = '0;
        c.par_en = s.par_addr_strap_hi | s.par_addr_strap_lo;
        c.par_base = pt[{s.par_addr_strap_hi, s.par_addr_strap_lo}];
        c.par_mode = sca_pkg::sca_par_mode_t'({s.par_ext_cap_strap, s.par_pad_mode_strap});
        c.uart_a_en = s.uart_a_addr_strap_hi | s.uart_a_addr_strap_lo;
        c.uart_a_base = at[{s.uart_a_addr_strap_hi, s.uart_a_addr_strap_lo}];
        c.uart_b_en = s.uart_b_addr_strap_hi | s.uart_b_addr_strap_lo;
        c.uart_b_base = bt[{s.uart_b_addr_strap_hi, s.uart_b_addr_strap_lo}];
        c.disk_if = sca_pkg::sca_disk_t'({s.disk_if_enable_strap, s.disk_if_addr_strap});
        c.floppy_en = s.floppy_enable_strap ? 1'b1 : sw[0];
        c.floppy_sec = s.floppy_enable_strap ? s.floppy_addr_strap : sw[1];
        c.floppy_mode2_ok = ~s.floppy_enable_strap;
        c.data_rate_out = s.floppy_enable_strap;
        c.cfg_sel_addr = s.floppy_addr_strap ? 10'h370 : 10'h3f0;
        c.cfg_dat_addr = s.floppy_addr_strap ? 10'h371 : 10'h3f1;
        return c;
    endfunction

    task automatic check(input string name, input logic [63:0] exp_v, input logic [63:0] got);
        check_count++;
        if (got !== exp_v) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp_v, got);
        end
    endtask

    // A disabled function has no meaningful base, so only its enable is compared.
    task automatic chk_cfg(input logic [1:0] sw);
        seen = cfg;
        if (seen.par_en === 1'b0) seen.par_base = '0;
        if (seen.uart_a_en === 1'b0) seen.uart_a_base = '0;
        if (seen.uart_b_en === 1'b0) seen.uart_b_base = '0;
        check("cfg", 64'(expect_cfg(latched, sw)), 64'(seen));
    endtask

    task automatic final_report();
        $display("Checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            latched = (i < 4) ? sca_pkg::sca_straps_t'({6{i[1:0]}}) : r[11:0];
            sel = latched.floppy_addr_strap ? 10'h370 : 10'h3f0;
            dat = sel + 10'h001;
            other = sel ^ 10'h080;
            @(negedge clk);
            rst_b = 1'b0;
            straps = latched;
            repeat (10) @(negedge clk);
            rst_b = 1'b1;
            host.idle();
            host.idle();
            straps = ~latched;
            host.put(sel, sca_pkg::SCA_KEY_ENTER);
            host.idle();
            host.idle();
            check("mode_after_reset", 64'(1'b0), 64'(cfg_mode));
            chk_cfg(2'b00);
            host.put(dat, 8'h00);
            host.put(sel, sca_pkg::SCA_KEY_ENTER);
            host.idle();
            check("mode_cancel", 64'(1'b0), 64'(cfg_mode));
            host.unlock(other);
            check("mode_wrong_port", 64'(1'b0), 64'(cfg_mode));
            host.put(sel, 8'h00);
            host.put(dat, 8'h5a);
            host.idle();
            check("data_wr_locked", 64'(1'b0), 64'(cfg_data_wr));
            host.unlock(sel);
            check("mode_enter", 64'(1'b1), 64'(cfg_mode));
            host.put(sel, 8'h05);
            host.put(dat, r[23:16]);
            host.idle();
            check("data_wr", 64'(1'b1), 64'(cfg_data_wr));
            check("data", 64'(r[23:16]), 64'(cfg_data));
            check("index", 64'(4'h5), 64'(cfg_index));
            host.put(sel, sca_pkg::SCA_KEY_ENTER);
            host.put(dat, r[31:24]);
            host.idle();
            check("data_wr_bad_index", 64'(1'b0), 64'(cfg_data_wr));
            host.put(sel, 8'(sca_pkg::SCA_IDX_FLOPPY));
            host.put(dat, 8'h03);
            host.idle();
            host.idle();
            chk_cfg(2'b11);
            host.put(sel, sca_pkg::SCA_KEY_EXIT);
            host.idle();
            check("mode_exit", 64'(1'b0), 64'(cfg_mode));
            host.put(sel, sca_pkg::SCA_KEY_ENTER);
            host.idle();
            $display("Test %0d done", i);
        end
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule // tb_strap_config_and_unlock
